// ---- src/dram_io_address_typing.sv ----
// Functional notes
// [RULE1] Lower ceiling stores address bits 39..23, 8-Mbyte units, lower bits dropped.
// [RULE2] Addresses below the lower ceiling are DRAM; the ceiling itself is first I/O byte.
// [RULE3] With upper enable set, 4 Gbytes up to the upper ceiling is DRAM.
// [RULE4] Software should program the upper ceiling above 4 Gbytes.
// [RULE5] Upper ceiling uses the same bits 39..23 layout as the lower one.
// [RULE6] Range base registers store base address bits 39..12, 4-Kbyte aligned.
// [RULE7] Inside an active range, writes go to DRAM when bit 3 is set.
// [RULE8] Inside an active range, reads come from DRAM when bit 4 is set.
// [RULE9] Each range has a mask register with its mask in bits 39..12.
// [RULE10] A range steers only while bit 11 of its mask register is set.
// [RULE11] Two independent ranges, each one base and one mask register.
// [RULE12] Hit when address and base agree on every masked bit 39..12.
// [RULE13] Reserved bits of all these registers read as zero.
`default_nettype none
`include "dram_io_map.svh"

module dram_io_address_typing (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Model-specific register port
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  output logic msr_ack,
  output logic msr_err,
  output logic [63:0] msr_rdata,
  // System configuration
  input wire logic upper_ceiling_enable,
  // Access request from the core
  input wire logic req_valid,
  input wire logic req_write,
  input wire dram_io_pkg::paddr_t req_addr,
  // Decode answer
  output logic resp_valid,
  output dram_io_pkg::target_t resp_target
);
  import dram_io_pkg::*;

  // Readback images; unstored bits are forced to zero
  function automatic logic [63:0] pack_ceil(input ceil_t c);
    pack_ceil = {24'h00_0000, c, 23'h00_0000}; // [RULE13]
  endfunction : pack_ceil

  function automatic logic [63:0] pack_base(input range_t b, input logic rd, input logic wr);
    pack_base = {24'h00_0000, b, 7'h00, rd, wr, 3'h0}; // [RULE13]
  endfunction : pack_base

  function automatic logic [63:0] pack_mask(input range_t m, input logic v);
    pack_mask = {24'h00_0000, m, v, 11'h000}; // [RULE13]
  endfunction : pack_mask

  // Stored state
  ceil_t ceil_reg;
  ceil_t upper_ceil_reg;
  range_t base_reg [2];
  range_t mask_reg [2];
  logic valid_reg [2];
  logic rd_reg [2];
  logic wr_reg [2];
  logic msr_ack_reg, msr_err_reg, resp_valid_reg;
  logic [63:0] msr_rdata_reg;
  target_t resp_target_reg;

  // Register address decode
  logic sel_ceil, sel_upper, sel_any;
  logic sel_base [2];
  logic sel_mask [2];
  assign sel_ceil = msr_addr == `OFF_CEIL;
  assign sel_upper = msr_addr == `OFF_UPPER_CEIL;
  assign sel_base[0] = msr_addr == `OFF_IO_BASE0; // [RULE11]
  assign sel_base[1] = msr_addr == `OFF_IO_BASE1;
  assign sel_mask[0] = msr_addr == `OFF_IO_MASK0;
  assign sel_mask[1] = msr_addr == `OFF_IO_MASK1;
  assign sel_any = sel_ceil | sel_upper | sel_base[0] | sel_base[1] | sel_mask[0] | sel_mask[1];

  // Read data selection; unknown addresses read zero
  logic [63:0] rdata_next;
  assign rdata_next = sel_ceil ? pack_ceil(ceil_reg) :
                      sel_upper ? pack_ceil(upper_ceil_reg) :
                      sel_base[0] ? pack_base(base_reg[0], rd_reg[0], wr_reg[0]) :
                      sel_base[1] ? pack_base(base_reg[1], rd_reg[1], wr_reg[1]) :
                      sel_mask[0] ? pack_mask(mask_reg[0], valid_reg[0]) :
                      sel_mask[1] ? pack_mask(mask_reg[1], valid_reg[1]) : 64'h0000_0000_0000_0000;

  // Ceiling registers keep only the 8-Mbyte field
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ceil_reg <= `CEIL_RESET;
      upper_ceil_reg <= `CEIL_RESET;
    end else begin
      if (msr_wr && sel_ceil) ceil_reg <= msr_wdata[`ADDR_MSB:`CEIL_LSB]; // [RULE1]
      if (msr_wr && sel_upper) upper_ceil_reg <= msr_wdata[`ADDR_MSB:`CEIL_LSB]; // [RULE5]
    end
  end

  // Range registers, one base and one mask per range
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 2; i++) begin
        base_reg[i] <= `RANGE_RESET;
        mask_reg[i] <= `RANGE_RESET;
        valid_reg[i] <= `STEER_RESET;
        rd_reg[i] <= `STEER_RESET;
        wr_reg[i] <= `STEER_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (msr_wr && sel_base[i]) begin
          base_reg[i] <= msr_wdata[`ADDR_MSB:`RANGE_LSB]; // [RULE6]
          rd_reg[i] <= msr_wdata[`READ_STEER_BIT];
          wr_reg[i] <= msr_wdata[`WRITE_STEER_BIT];
        end
        if (msr_wr && sel_mask[i]) begin
          mask_reg[i] <= msr_wdata[`ADDR_MSB:`RANGE_LSB]; // [RULE9]
          valid_reg[i] <= msr_wdata[`RANGE_VALID_BIT]; // [RULE10]
        end
      end
    end
  end

  // Register port answer: one cycle after the strobe, error on a stray address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      msr_ack_reg <= 1'h0;
      msr_err_reg <= 1'h0;
      msr_rdata_reg <= 64'h0000_0000_0000_0000;
    end else begin
      msr_ack_reg <= msr_wr | msr_rd;
      msr_err_reg <= (msr_wr | msr_rd) & ~sel_any;
      msr_rdata_reg <= msr_rd ? rdata_next : 64'h0000_0000_0000_0000;
    end
  end

  // Two range matchers, independent of each other
  io_range_if rif [2] ();
  for (genvar g = 0; g < 2; g++) begin : g_range
    assign rif[g].base = base_reg[g];
    assign rif[g].mask = mask_reg[g];
    assign rif[g].valid = valid_reg[g];
    assign rif[g].read_steer_memory = rd_reg[g];
    assign rif[g].write_steer_memory = wr_reg[g];
    assign rif[g].addr = req_addr;
    assign rif[g].write = req_write;
    io_range_match u_match (
      .r(rif[g])
    );
  end

  // Ceiling compares at 8-Mbyte grain; the ceiling byte itself is I/O
  logic below_ceil, in_upper, hit0, hit1, dram_sel;
  assign below_ceil = req_addr[`ADDR_MSB:`CEIL_LSB] < ceil_reg; // [RULE2]
  assign in_upper = upper_ceiling_enable && (req_addr >= `FOUR_GB) &&
                    (req_addr[`ADDR_MSB:`CEIL_LSB] < upper_ceil_reg); // [RULE3]
  assign hit0 = rif[0].hit;
  assign hit1 = rif[1].hit;
  // Ranges override the ceilings; range 0 wins an overlap so the answer stays defined
  assign dram_sel = hit0 ? rif[0].to_dram :
                    hit1 ? rif[1].to_dram : (below_ceil | in_upper); // [RULE7] [RULE8]

  // Registered decode answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_reg <= 1'h0;
      resp_target_reg <= TGT_IO;
    end else begin
      resp_valid_reg <= req_valid;
      resp_target_reg <= dram_sel ? TGT_DRAM : TGT_IO;
    end
  end

  assign msr_ack = msr_ack_reg;
  assign msr_err = msr_err_reg;
  assign msr_rdata = msr_rdata_reg;
  assign resp_valid = resp_valid_reg;
  assign resp_target = resp_target_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  resp_latency_a: assert property (req_valid |=> resp_valid && $past(req_valid)) // [RULE2]
    else $error("decode answer missing one cycle after request");
  ceil_store_a: assert property (msr_wr && sel_ceil |=> // [RULE1]
                                 ceil_reg == $past(msr_wdata[39:23]))
    else $error("lower ceiling field not stored");
  upper_store_a: assert property (msr_wr && sel_upper |=> // [RULE5]
                                  upper_ceil_reg == $past(msr_wdata[39:23]))
    else $error("upper ceiling field not stored");
  lower_dram_a: assert property (req_valid && !hit0 && !hit1 && below_ceil |=> // [RULE2]
                                 resp_target == TGT_DRAM)
    else $error("address below lower ceiling not sent to DRAM");
  upper_gate_a: assert property (req_valid && !upper_ceiling_enable && !hit0 && // [RULE3]
                                 !hit1 && !below_ceil |=> resp_target == TGT_IO)
    else $error("upper region used while disabled");
  upper_dram_a: assert property (req_valid && upper_ceiling_enable && !hit0 && // [RULE5]
                                 !hit1 && req_addr >= `FOUR_GB && req_addr[39:23] < upper_ceil_reg
                                 |=> resp_target == TGT_DRAM)
    else $error("upper region address not sent to DRAM");
  write_steer_a: assert property (req_valid && req_write && hit0 |=> // [RULE7]
                                  resp_target == target_t'($past(wr_reg[0])))
    else $error("write steering bit ignored");
  read_steer_a: assert property (req_valid && !req_write && !hit0 && hit1 |=> // [RULE8]
                                 resp_target == target_t'($past(rd_reg[1])))
    else $error("read steering bit ignored");
  range_match_a: assert property (hit0 |-> valid_reg[0] && // [RULE12]
                                  ((req_addr[39:12] ^ base_reg[0]) & mask_reg[0]) == 28'h000_0000)
    else $error("range hit without masked match");
  mask_read_a: assert property (msr_rd && sel_mask[1] |=> // [RULE9]
                                msr_rdata[39:12] == $past(mask_reg[1]) &&
                                msr_rdata[11] == $past(valid_reg[1]) &&
                                msr_rdata[10:0] == 11'h000)
    else $error("mask readback wrong");
  reserved_zero_a: assert property (msr_ack |-> msr_rdata[63:40] == 24'h00_0000) // [RULE13]
    else $error("reserved bits read nonzero");
  ceil_low_zero_a: assert property (msr_rd && (sel_ceil || sel_upper) |=> // [RULE13]
                                    msr_rdata[22:0] == 23'h00_0000)
    else $error("ceiling low bits read nonzero");

  // Main scenarios that the bench is expected to reach
  range_write_c: cover property (req_valid && req_write && hit0);
  range_read_c: cover property (req_valid && !req_write && hit1);
  upper_hit_c: cover property (req_valid && in_upper && !below_ceil);
  upper_off_c: cover property (req_valid && !upper_ceiling_enable && req_addr >= `FOUR_GB);
  stray_msr_c: cover property (msr_rd && !sel_any);
endmodule : dram_io_address_typing

`default_nettype wire

// ---- src/dram_io_map.svh ----
`ifndef DRAM_IO_MAP_SVH
`define DRAM_IO_MAP_SVH

// Register addresses on the model-specific register port
`define OFF_IO_BASE0 32'hc001_0016
`define OFF_IO_MASK0 32'hc001_0017
`define OFF_IO_BASE1 32'hc001_0018
`define OFF_IO_MASK1 32'hc001_0019
`define OFF_CEIL 32'hc001_001a
`define OFF_UPPER_CEIL 32'hc001_001d

// Field positions
`define ADDR_MSB 39
`define CEIL_LSB 23
`define RANGE_LSB 12
`define RANGE_VALID_BIT 11
`define READ_STEER_BIT 4
`define WRITE_STEER_BIT 3

// Start of the upper DRAM region (4 Gbytes)
`define FOUR_GB 40'h01_0000_0000

// Reset values
`define CEIL_RESET 17'h0_0000
`define RANGE_RESET 28'h000_0000
`define STEER_RESET 1'h0

`endif

// ---- src/dram_io_pkg.sv ----
`default_nettype none

package dram_io_pkg;
  // Physical address as issued by the core
  typedef logic [39:0] paddr_t;
  // Destination of a decoded access
  typedef enum logic {TGT_IO, TGT_DRAM} target_t;
  // Stored ceiling field, 8-Mbyte units
  typedef logic [16:0] ceil_t;
  // Stored range base or mask, 4-Kbyte units
  typedef logic [27:0] range_t;
endpackage : dram_io_pkg

`default_nettype wire

// ---- src/io_range_if.sv ----
`default_nettype none

interface io_range_if;
  import dram_io_pkg::*;
  range_t base;
  range_t mask;
  logic valid;
  logic read_steer_memory;
  logic write_steer_memory;
  paddr_t addr;
  logic write;
  logic hit;
  logic to_dram;
  // Register side owns the settings, matcher answers
  modport owner (output base, mask, valid, read_steer_memory, write_steer_memory, addr, write,
                 input hit, to_dram);
  modport matcher (input base, mask, valid, read_steer_memory, write_steer_memory, addr, write,
                   output hit, to_dram);
endinterface : io_range_if

`default_nettype wire

// ---- src/io_range_match.sv ----
`default_nettype none
`include "dram_io_map.svh"

module io_range_match (
  // Range settings and request
  io_range_if.matcher r
);
  import dram_io_pkg::*;

  // Masked compare on the 4-Kbyte page bits only
  assign r.hit = r.valid && ((r.addr[`ADDR_MSB:`RANGE_LSB] & r.mask) == (r.base & r.mask)); // [RULE12] [RULE10]
  // Direction picks the steering bit
  assign r.to_dram = r.write ? r.write_steer_memory : r.read_steer_memory; // [RULE7] [RULE8]
endmodule : io_range_match

`default_nettype wire

// ---- test/core_request_model.sv ----
`default_nettype none

module core_request_model (
  // Clock
  input wire logic clk_sys,
  // Request to the decoder
  output logic req_valid,
  output logic req_write,
  output dram_io_pkg::paddr_t req_addr,
  // Decode answer
  input wire logic resp_valid,
  input wire dram_io_pkg::target_t resp_target
);
  timeunit 1ns;
  timeprecision 1ps;
  import dram_io_pkg::*;

  // Idle core at time zero
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
  end

  // One load or store, answer taken one cycle after the request edge
  task automatic issue(input paddr_t a, input logic w, output logic ok, output target_t t);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr <= ~a; // Released lines must not keep the old address
    #1;
    ok = resp_valid;
    t = resp_target;
  endtask : issue
endmodule : core_request_model

`default_nettype wire

// ---- test/dram_io_address_typing_tb.sv ----
`default_nettype none
`include "dram_io_map.svh"

// Counts every comparison, reports a mismatch at once
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end

module dram_io_address_typing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dram_io_pkg::*;
  logic clk_sys, rst_b, msr_wr, msr_rd, msr_ack, msr_err, upper_ceiling_enable;
  logic [31:0] msr_addr;
  logic [63:0] msr_wdata, msr_rdata;
  logic req_valid, req_write, resp_valid;
  paddr_t req_addr;
  target_t resp_target;
  int fails, checked;
  logic [31:0] offs [6] = '{`OFF_IO_BASE0, `OFF_IO_MASK0, `OFF_IO_BASE1, `OFF_IO_MASK1,
                            `OFF_CEIL, `OFF_UPPER_CEIL};
  logic [63:0] imgs [6] = '{64'h0000_00ff_ffff_f018, 64'h0000_00ff_ffff_f800,
                            64'h0000_00ff_ffff_f018, 64'h0000_00ff_ffff_f800,
                            64'h0000_00ff_ff80_0000, 64'h0000_00ff_ff80_0000};

  dram_io_address_typing DUT (.clk_sys(clk_sys), .rst_b(rst_b), .msr_wr(msr_wr),
    .msr_rd(msr_rd), .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_ack(msr_ack),
    .msr_err(msr_err), .msr_rdata(msr_rdata), .upper_ceiling_enable(upper_ceiling_enable),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .resp_valid(resp_valid), .resp_target(resp_target));

  core_request_model core (.clk_sys(clk_sys), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .resp_valid(resp_valid), .resp_target(resp_target));

  // Closing report
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // One register strobe, ack checked one cycle later
  task automatic reg_io(input logic wr, input logic [31:0] a, input logic [63:0] d,
                        input logic err_ex, input logic [63:0] rd_ex);
    @(posedge clk_sys);
    msr_wr <= wr;
    msr_rd <= ~wr;
    msr_addr <= a;
    msr_wdata <= d;
    @(posedge clk_sys);
    msr_wr <= 1'b0;
    msr_rd <= 1'b0;
    msr_wdata <= ~d;
    #1;
    `CHK("ack", 1'b1, msr_ack)
    `CHK("err", err_ex, msr_err)
    if (!wr) `CHK("rdata", rd_ex, msr_rdata)
  endtask : reg_io

  task automatic dec(input paddr_t a, input logic w, input target_t ex);
    logic ok;
    target_t t;
    core.issue(a, w, ok, t);
    `CHK("resp_valid", 1'b1, ok)
    `CHK("target", ex, t)
  endtask : dec

  // Cleared fields, unmapped place, then all-ones images
  task automatic t_images();
    for (int i = 0; i < 6; i++) reg_io(1'b0, offs[i], '0, 1'b0, '0);
    reg_io(1'b1, 32'hc001_001b, '1, 1'b1, '0);
    reg_io(1'b0, 32'hc001_001b, '0, 1'b1, '0);
    for (int i = 0; i < 6; i++) begin
      reg_io(1'b1, offs[i], '1, 1'b0, '0);
      reg_io(1'b0, offs[i], '0, 1'b0, imgs[i]);
      reg_io(1'b1, offs[i], '0, 1'b0, '0);
    end
  endtask : t_images

  // Lower ceiling at 1 GB, written with junk in dropped bits
  task automatic t_lower();
    reg_io(1'b1, `OFF_CEIL, 64'hffff_ff00_407f_ffff, 1'b0, '0);
    reg_io(1'b0, `OFF_CEIL, '0, 1'b0, 64'h0000_0000_4000_0000);
    dec(40'h00_3fff_ffff, 1'b0, TGT_DRAM);
    dec(40'h00_4000_0000, 1'b1, TGT_IO);
  endtask : t_lower

  // Upper region from 4 GB to 8 GB, only while enabled
  task automatic t_upper();
    reg_io(1'b1, `OFF_UPPER_CEIL, 64'h0000_0002_0000_0000, 1'b0, '0);
    reg_io(1'b0, `OFF_UPPER_CEIL, '0, 1'b0, 64'h0000_0002_0000_0000);
    dec(40'h01_0000_0000, 1'b0, TGT_IO);
    // Enable changes on an edge, like every other input
    @(posedge clk_sys);
    upper_ceiling_enable <= 1'b1;
    dec(40'h01_0000_0000, 1'b0, TGT_DRAM);
    dec(40'h01_ffff_ffff, 1'b1, TGT_DRAM);
    dec(40'h02_0000_0000, 1'b0, TGT_IO);
    dec(40'h00_ffff_f000, 1'b0, TGT_IO);
  endtask : t_upper

  // Two ranges with opposite steering
  task automatic t_ranges();
    reg_io(1'b1, `OFF_IO_BASE0, 64'h0000_0000_c000_0010, 1'b0, '0);
    reg_io(1'b1, `OFF_IO_MASK0, 64'h0000_00ff_ffff_f000, 1'b0, '0);
    dec(40'h00_c000_0abc, 1'b0, TGT_IO);
    reg_io(1'b1, `OFF_IO_MASK0, 64'h0000_00ff_ffff_f800, 1'b0, '0);
    dec(40'h00_c000_0abc, 1'b0, TGT_DRAM);
    dec(40'h00_c000_0abc, 1'b1, TGT_IO);
    dec(40'h00_c000_1000, 1'b0, TGT_IO);
    reg_io(1'b1, `OFF_IO_BASE1, 64'h0000_0001_2000_0008, 1'b0, '0);
    reg_io(1'b1, `OFF_IO_MASK1, 64'h0000_00ff_f000_0800, 1'b0, '0);
    dec(40'h01_2345_6000, 1'b0, TGT_IO);
    dec(40'h01_2345_6000, 1'b1, TGT_DRAM);
    dec(40'h01_3000_0000, 1'b0, TGT_DRAM);
  endtask : t_ranges

  // 25 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    msr_addr = '0;
    msr_wdata = '0;
    upper_ceiling_enable = 1'b0;
    fails = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_images();
    t_lower();
    t_upper();
    t_ranges();
    stop_test();
  end
endmodule : dram_io_address_typing_tb

`default_nettype wire
